// ===== core/pcs_synth_ctrl.v
// clock synthesizer control: config store, loop model, output selection and gating
// How it works
// RULE1 - reference divider ratio is eight bits
// RULE2 - feedback divider ratio is eleven bits
// RULE3 - post divider ratio is five bits
// RULE4 - output equals reference times feedback over reference-post product
// RULE5 - main output picks synth, reference, or reference/2P
// RULE6 - aux output picks reference or main copy
// RULE7 - enable low: loop stopped, main low
// RULE8 - aux main-copy held low when enable low
// RULE9 - sleep low stops everything, both outputs low
// RULE10 - disabled outputs drive steady low
// RULE11 - one control pin, function fixed by config
// RULE12 - control pin high means normal, bank one
// RULE13 - bank select: low bank zero, high one
// RULE14 - per-output drive strength, standard by default
// RULE15 - settings come from one-time programmed store
// RULE16 - wait loop settle after sleep exit
// RULE17 - outputs gate synchronously, no truncated pulses
// RULE18 - bank change applies set whole, relocks first
`include "pcs_regs.vh"
module pcs_synth_ctrl #(
    parameter RW         = 8,
    parameter MW         = 11,
    parameter PW         = 5,
    parameter SETTLE_CYC = `PCS_SETTLE_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        reference_clock_in,
    input  wire        ctl_pin,
    output wire        main_clock_out,
    output wire        aux_clock_out,
    output wire [1:0]  main_drive,
    output wire [1:0]  aux_drive
);
    localparam AW = MW + 2;

    // one-time programmed configuration store
    reg  [31:0] div0_ff;
    reg  [31:0] out0_ff;
    reg  [31:0] div1_ff;
    reg  [31:0] out1_ff;
    reg  [31:0] ctrl_ff;
    // bus answer
    reg         ack_ff;
    reg  [31:0] rdata_ff;
    // active setting set
    reg  [31:0] act_div_ff;
    reg  [31:0] act_out_ff;
    reg         act_bank_ff;
    reg         lock_req_ff;
    reg  [31:0] settle_ff;
    reg         locked_ff;
    // loop model
    reg         ref_ff;
    reg  [AW:0] acc_ff;
    reg  [1:0]  mdrv_ff;
    reg  [1:0]  adrv_ff;

    reg  [31:0] nxt_rdata;

    wire        req      = avs_read | avs_write;
    wire        wr_take  = avs_write & ack_ff;
    wire        burned   = ctrl_ff[`PCS_BURN_BIT];
    wire        wr_ok    = wr_take & ~burned;
    wire [1:0]  pin_func = ctrl_ff[`PCS_FUNC_MSB:`PCS_FUNC_LSB];

    // selects one word of the two banks
    function [31:0] bank_word;
        input        sel;
        input [31:0] w0;
        input [31:0] w1;
        begin
            bank_word = sel ? w1 : w0;
        end
    endfunction

    // control pin meaning per configured function
    wire oe_low     = (pin_func == `PCS_FUNC_OE) & ~ctl_pin; // RULE11
    wire sleep_low  = (pin_func == `PCS_FUNC_SLEEP) & ~ctl_pin; // RULE11
    wire bank_mode  = (pin_func == `PCS_FUNC_BANK);
    // pin high gives normal operation; bank one unless bank-select drives low
    wire want_bank  = bank_mode ? ctl_pin : 1'b1; // RULE12 RULE13

    // register bus
    assign avs_waitrequest = req & ~ack_ff;
    assign avs_readdata    = rdata_ff;

    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (avs_address == `PCS_OFS_DIV0) begin
            nxt_rdata = div0_ff;
        end else if (avs_address == `PCS_OFS_OUT0) begin
            nxt_rdata = out0_ff;
        end else if (avs_address == `PCS_OFS_DIV1) begin
            nxt_rdata = div1_ff;
        end else if (avs_address == `PCS_OFS_OUT1) begin
            nxt_rdata = out1_ff;
        end else if (avs_address == `PCS_OFS_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (avs_address == `PCS_OFS_STAT) begin
            nxt_rdata = {26'h0, aux_clock_out, main_clock_out, act_bank_ff,
                         sleep_low, oe_low, locked_ff};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (avs_read & ~ack_ff)
                rdata_ff <= nxt_rdata;
        end
    end

    // configuration writes land only until the burn bit is set
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            div0_ff <= `PCS_DIV_RST;
            out0_ff <= `PCS_OUT_RST; // RULE14
            div1_ff <= `PCS_DIV_RST;
            out1_ff <= `PCS_OUT_RST;
            ctrl_ff <= `PCS_CTRL_RST;
        end else if (wr_ok) begin // RULE15
            if (avs_address == `PCS_OFS_DIV0) begin
                div0_ff <= avs_writedata & 32'h1f07_ffff;
            end else if (avs_address == `PCS_OFS_OUT0) begin
                out0_ff <= avs_writedata & 32'h0000_0337;
            end else if (avs_address == `PCS_OFS_DIV1) begin
                div1_ff <= avs_writedata & 32'h1f07_ffff;
            end else if (avs_address == `PCS_OFS_OUT1) begin
                out1_ff <= avs_writedata & 32'h0000_0337;
            end else if (avs_address == `PCS_OFS_CTRL) begin
                ctrl_ff <= avs_writedata & 32'h0000_0013;
            end
        end
    end

    // bank and settle control
    wire cfg_wr   = wr_ok & (avs_address != `PCS_OFS_STAT);
    wire bank_chg = (want_bank != act_bank_ff);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            act_bank_ff <= 1'b1;
            act_div_ff  <= `PCS_DIV_RST;
            act_out_ff  <= `PCS_OUT_RST;
            lock_req_ff <= 1'b1;
        end else begin
            lock_req_ff <= 1'b0;
            if (bank_chg | cfg_wr) begin
                // whole set taken at once, then the loop relocks
                act_bank_ff <= want_bank; // RULE13
                act_div_ff  <= bank_word(want_bank, div0_ff, div1_ff); // RULE18
                act_out_ff  <= bank_word(want_bank, out0_ff, out1_ff); // RULE18
                lock_req_ff <= 1'b1; // RULE18
            end else begin
                act_div_ff  <= bank_word(act_bank_ff, div0_ff, div1_ff);
                act_out_ff  <= bank_word(act_bank_ff, out0_ff, out1_ff);
            end
        end
    end

    // settle counter restarts on sleep and on every new setting set
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_ff <= 32'h0000_0000;
            locked_ff <= 1'b0;
        end else if (sleep_low | lock_req_ff) begin // RULE9 RULE18
            settle_ff <= 32'h0000_0000;
            locked_ff <= 1'b0;
        end else if (!locked_ff) begin
            if (settle_ff + 32'h0000_0001 >= SETTLE_CYC) begin
                locked_ff <= 1'b1; // RULE16
            end else begin
                settle_ff <= settle_ff + 32'h0000_0001;
            end
        end
    end

    // loop model
    wire [RW-1:0] r_div = act_div_ff[`PCS_R_MSB:`PCS_R_LSB]; // RULE1
    wire [MW-1:0] m_div = act_div_ff[`PCS_M_MSB:`PCS_M_LSB]; // RULE2
    wire [PW-1:0] p_div = act_div_ff[`PCS_P_MSB:`PCS_P_LSB]; // RULE3
    wire [AW:0]   r_eff = (r_div == {RW{1'b0}}) ? {{AW{1'b0}}, 1'b1}
                                                : {{(AW+1-RW){1'b0}}, r_div};
    wire [AW:0]   m_two = {{(AW-MW){1'b0}}, m_div, 1'b0};
    wire          ref_rise = reference_clock_in & ~ref_ff;
    // oscillator stops only in sleep; loop stops in sleep or enable low
    wire          osc_run  = ~sleep_low; // RULE9
    wire          loop_run = osc_run & ~oe_low; // RULE7
    wire          vco_tick = loop_run & (acc_ff >= r_eff);
    wire [AW:0]   acc_add  = ref_rise ? m_two : {(AW+1){1'b0}};
    wire [AW:0]   acc_sub  = vco_tick ? r_eff : {(AW+1){1'b0}};

    // each reference edge adds 2M, each loop edge removes R: edges = 2*reference_frequency*M/R
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_ff <= 1'b0;
            acc_ff <= {(AW+1){1'b0}};
        end else begin
            ref_ff <= reference_clock_in;
            if (!loop_run)
                acc_ff <= {(AW+1){1'b0}}; // RULE7
            else
                acc_ff <= acc_ff + acc_add - acc_sub; // RULE4
        end
    end

    wire synth_clk;
    wire refdiv_clk;

    // post divider: toggles every P loop edges, synth_frequency = reference_frequency*M/(R*P)
    pcs_div_toggle #(
        .W       (PW)
    ) u_post_div (
        .clk     (clk),
        .rst     (rst),
        .run     (loop_run),
        .tick    (vco_tick),
        .ratio   (p_div),
        .clk_out (synth_clk)
    ); // RULE3 RULE4

    // reference divided by twice the post ratio
    pcs_div_toggle #(
        .W       (PW)
    ) u_ref_div (
        .clk     (clk),
        .rst     (rst),
        .run     (osc_run),
        .tick    (ref_rise),
        .ratio   (p_div),
        .clk_out (refdiv_clk)
    ); // RULE5

    // output selection and gating
    wire [1:0] src0 = act_out_ff[`PCS_SRC0_MSB:`PCS_SRC0_LSB];
    wire       src1 = act_out_ff[`PCS_SRC1_BIT];
    wire       main_src = (src0 == `PCS_SRC_REF)    ? reference_clock_in :
                          (src0 == `PCS_SRC_REFDIV) ? refdiv_clk : synth_clk; // RULE5
    wire       aux_src  = (src1 == `PCS_AUX_MAIN) ? main_clock_out
                                                  : reference_clock_in; // RULE6
    wire       main_en  = locked_ff & ~sleep_low & ~oe_low; // RULE7 RULE9 RULE16
    // a reference-sourced aux keeps running while enable is low
    wire       aux_en   = locked_ff & ~sleep_low &
                          ((src1 == `PCS_AUX_REF) | ~oe_low); // RULE7 RULE8 RULE9

    pcs_out_gate u_main_gate (
        .clk (clk),
        .rst (rst),
        .src (main_src),
        .en  (main_en),
        .out (main_clock_out)
    ); // RULE10 RULE17

    pcs_out_gate u_aux_gate (
        .clk (clk),
        .rst (rst),
        .src (aux_src),
        .en  (aux_en),
        .out (aux_clock_out)
    ); // RULE10 RULE17

    // drive strength, reserved code falls back to standard
    wire [1:0] d0 = act_out_ff[`PCS_DRV0_MSB:`PCS_DRV0_LSB];
    wire [1:0] d1 = act_out_ff[`PCS_DRV1_MSB:`PCS_DRV1_LSB];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mdrv_ff <= `PCS_DRV_STD; // RULE14
            adrv_ff <= `PCS_DRV_STD; // RULE14
        end else begin
            mdrv_ff <= (d0 == 2'h3) ? `PCS_DRV_STD : d0; // RULE14
            adrv_ff <= (d1 == 2'h3) ? `PCS_DRV_STD : d1; // RULE14
        end
    end

    assign main_drive = mdrv_ff;
    assign aux_drive  = adrv_ff;
endmodule

// ===== core/pcs_regs.vh
// register map, field positions, reset values and timing for the clock synth control
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// register byte offsets
`define PCS_OFS_DIV0       8'h00
`define PCS_OFS_OUT0       8'h04
`define PCS_OFS_DIV1       8'h08
`define PCS_OFS_OUT1       8'h0c
`define PCS_OFS_CTRL       8'h10
`define PCS_OFS_STAT       8'h14

// divider word fields
`define PCS_R_LSB          0
`define PCS_R_MSB          7
`define PCS_M_LSB          8
`define PCS_M_MSB          18
`define PCS_P_LSB          24
`define PCS_P_MSB          28
// output word fields
`define PCS_SRC0_LSB       0
`define PCS_SRC0_MSB       1
`define PCS_SRC1_BIT       2
`define PCS_DRV0_LSB       4
`define PCS_DRV0_MSB       5
`define PCS_DRV1_LSB       8
`define PCS_DRV1_MSB       9
// control word fields
`define PCS_FUNC_LSB       0
`define PCS_FUNC_MSB       1
`define PCS_BURN_BIT       4

// main source codes
`define PCS_SRC_SYNTH      2'h0
`define PCS_SRC_REF        2'h1
`define PCS_SRC_REFDIV     2'h2
// aux source codes
`define PCS_AUX_REF        1'b0
`define PCS_AUX_MAIN       1'b1
// drive strength codes
`define PCS_DRV_LOW        2'h0
`define PCS_DRV_STD        2'h1
`define PCS_DRV_HIGH       2'h2
// control pin function codes
`define PCS_FUNC_OE        2'h0
`define PCS_FUNC_SLEEP     2'h1
`define PCS_FUNC_BANK      2'h2

// reset values
`define PCS_DIV_RST        32'h0100_0101
`define PCS_OUT_RST        32'h0000_0110
`define PCS_CTRL_RST       32'h0000_0000

// loop settle time after sleep exit or bank change
`define PCS_SETTLE_US      2000
`define PCS_CLK_MHZ        100
`define PCS_SETTLE_CYC     (`PCS_SETTLE_US * `PCS_CLK_MHZ)

`endif

// ===== core/pcs_div_toggle.v
// divide-by-2n toggle divider driven by single-cycle ticks
module pcs_div_toggle #(
    parameter W = 5
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         run,
    input  wire         tick,
    input  wire [W-1:0] ratio,
    output wire         clk_out
);
    reg  [W-1:0] cnt_ff;
    reg          tgl_ff;
    wire [W-1:0] lim = (ratio == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : ratio;

    // output flips once per ratio ticks, so its period is 2*ratio ticks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= {W{1'b0}};
            tgl_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff <= {W{1'b0}};
            tgl_ff <= 1'b0;
        end else if (tick) begin
            if (cnt_ff + {{(W-1){1'b0}}, 1'b1} >= lim) begin
                cnt_ff <= {W{1'b0}};
                tgl_ff <= ~tgl_ff;
            end else begin
                cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign clk_out = tgl_ff;
endmodule

// ===== core/pcs_out_gate.v
// glitch-free clock output gate that forces a steady low when disabled
module pcs_out_gate (
    input  wire clk,
    input  wire rst,
    input  wire src,
    input  wire en,
    output wire out
);
    reg en_ff;
    reg out_ff;

    // enable only moves while the source is low, so no high pulse is cut short
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            en_ff  <= 1'b0;
            out_ff <= 1'b0;
        end else begin
            if (!src)
                en_ff <= en; // RULE17
            out_ff <= src & en_ff; // RULE10
        end
    end

    assign out = out_ff;
endmodule

// ===== bench/pcs_far_end.sv
// far side model: free-running reference source and rise counters on both outputs
module pcs_far_end #(
    parameter HALF = 4
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clr,
    input  wire logic        main_clock_out,
    input  wire logic        aux_clock_out,
    output logic             reference_clock_in,
    output logic [15:0]      main_rises,
    output logic [15:0]      aux_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ph;
    logic       main_q;
    logic       aux_q;
    // reference toggles every HALF clocks, well below clk/2
    always @(posedge clk) begin
        if (rst) begin
            ph <= 8'h0;
            reference_clock_in <= 1'h0;
        end else begin
            ph <= (ph == 8'(HALF - 1)) ? 8'h0 : ph + 8'h1;
            if (ph == 8'(HALF - 1)) reference_clock_in <= !reference_clock_in;
        end
        main_q <= main_clock_out;
        aux_q <= aux_clock_out;
        main_rises <= clr ? 16'h0 : main_rises + 16'(main_clock_out && !main_q);
        aux_rises <= clr ? 16'h0 : aux_rises + 16'(aux_clock_out && !aux_q);
    end
endmodule

// ===== bench/pcs_synth_ctrl_monitor.sv
// port checks for the clock synth control
`include "pcs_regs.vh"
module pcs_synth_ctrl_monitor #(
    parameter SETTLE_CYC = 20
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        ctl_pin,
    input wire logic        main_clock_out,
    input wire logic        aux_clock_out,
    input wire logic [1:0]  main_drive,
    input wire logic [1:0]  aux_drive
);
    logic [1:0] func_ff;
    logic       burn_ff;
    logic [5:0] oe_cnt_ff;
    logic [5:0] slp_cnt_ff;
    wire        ctrl_wr = avs_write && !avs_waitrequest && avs_address == `PCS_OFS_CTRL;
    wire        oe_low = func_ff == `PCS_FUNC_OE && !ctl_pin;
    wire        slp_low = func_ff == `PCS_FUNC_SLEEP && !ctl_pin;
    wire        both_low = !main_clock_out && !aux_clock_out;
    // shadow of the pin function and how long the pin has been held active
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            func_ff <= 2'h0;
            burn_ff <= 1'h0;
            oe_cnt_ff <= 6'h0;
            slp_cnt_ff <= 6'h0;
        end else begin
            if (ctrl_wr && !burn_ff) begin
                func_ff <= avs_writedata[1:0];
                burn_ff <= avs_writedata[4];
            end
            oe_cnt_ff <= oe_low ? oe_cnt_ff + {5'h0, !oe_cnt_ff[5]} : 6'h0;
            slp_cnt_ff <= slp_low ? slp_cnt_ff + {5'h0, !slp_cnt_ff[5]} : 6'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
    AST_ACK_DROP: assert property ((avs_read || avs_write) && !avs_waitrequest
        |=> avs_waitrequest || !(avs_read || avs_write)) else $error("ack held too long");
    AST_RD_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 8'h14
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_DRV_CODE: assert property (main_drive != 2'h3 && aux_drive != 2'h3)
        else $error("illegal drive code");
    AST_RST_STATE: assert property ($fell(rst) |-> main_drive == `PCS_DRV_STD
        && aux_drive == `PCS_DRV_STD && both_low) else $error("wrong state after reset");
    AST_SETTLE_RST: assert property ($fell(rst) |-> both_low [*8])
        else $error("output before settle");
    AST_OE_LOW: assert property (oe_cnt_ff >= 6'h14 |-> !main_clock_out)
        else $error("main output toggles while disabled");
    AST_SLEEP_LOW: assert property (slp_cnt_ff >= 6'h14 |-> both_low)
        else $error("output toggles in sleep");
    AST_SLEEP_EXIT: assert property ($fell(slp_low) |-> both_low [*8])
        else $error("output before settle after sleep");
    AST_BANK_SETTLE: assert property (func_ff == `PCS_FUNC_BANK && ctl_pin != $past(ctl_pin)
        |-> ##10 both_low [*8]) else $error("output during bank relock");
endmodule

// ===== bench/pcs_synth_ctrl_bench.sv
// self-checking bench for the clock synth control
`include "pcs_regs.vh"
module pcs_synth_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [31:0] dv;
        logic [31:0] ow;
        int          m;
        int          a;
        logic [3:0]  drv;
    } pcs_row_t;
    pcs_row_t    rows [5] = '{
        '{32'h0100_0101, 32'h0000_0111, 32, 32, 4'h5},
        '{32'h0200_0101, 32'h0000_0212, 8, 32, 4'h6},
        '{32'h0100_0304, 32'h0000_0000, 24, 32, 4'h0},
        '{32'h0100_0101, 32'h0000_0026, 16, 16, 4'h8},
        '{32'h0200_0101, 32'h0000_0333, 16, 32, 4'h5}};
    logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40};
    logic [31:0] re [6] = '{32'h0100_0101, 32'h110, 32'h0100_0101, 32'h110, 32'h0, 32'h0};
    logic        clk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        reference_clock_in;
    logic        ctl_pin;
    logic        main_clock_out;
    logic        aux_clock_out;
    logic [1:0]  main_drive;
    logic [1:0]  aux_drive;
    logic        clr;
    logic [15:0] main_rises;
    logic [15:0] aux_rises;
    logic [31:0] q;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    pcs_synth_ctrl #(.SETTLE_CYC(20)) dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .reference_clock_in(reference_clock_in), .ctl_pin(ctl_pin),
        .main_clock_out(main_clock_out), .aux_clock_out(aux_clock_out),
        .main_drive(main_drive), .aux_drive(aux_drive));
    pcs_far_end #(.HALF(4)) far (.clk(clk), .rst(rst), .clr(clr),
        .main_clock_out(main_clock_out), .aux_clock_out(aux_clock_out),
        .reference_clock_in(reference_clock_in), .main_rises(main_rises),
        .aux_rises(aux_rises));
    always #5 clk = ~clk;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cnt(input string what, input int exp, input int tol, input logic [15:0] got);
        n_compared++;
        if (^got === 1'bx || int'(got) + tol < exp || int'(got) > exp + tol) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // one Avalon access: hold until waitrequest is seen low, then release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 100);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 100) err_total++;
    endtask
    task automatic meas(input int n);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pin(input logic v);
        @(posedge clk) ctl_pin <= v;
        repeat (40) @(posedge clk);
    endtask
    initial begin
        clk = 0;
        rst = 1;
        avs_address = 8'h0;
        avs_read = 0;
        avs_write = 0;
        avs_writedata = 32'h0;
        ctl_pin = 1;
        clr = 0;
        repeat (3) @(negedge clk);
        chk_word("reset drives", 32'h5, {28'h0, main_drive, aux_drive});
        @(posedge clk) rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(0, ra[i], 32'h0);
            chk_word("reset value", re[i], q);
        end
        $display("test reset_values done");
        foreach (rows[i]) begin
            bus(1, `PCS_OFS_DIV1, rows[i].dv);
            bus(1, `PCS_OFS_OUT1, rows[i].ow);
            pin(1);
            meas(256);
            chk_cnt("main rises", rows[i].m, 1, main_rises);
            chk_cnt("aux rises", rows[i].a, 1, aux_rises);
            chk_word("drives", {28'h0, rows[i].drv}, {28'h0, main_drive, aux_drive});
            $display("test row %0d done", i);
        end
        bus(1, `PCS_OFS_DIV1, 32'h0100_0101);
        bus(1, `PCS_OFS_OUT1, 32'h111);
        pin(0);
        meas(256);
        chk_cnt("main with enable low", 0, 0, main_rises);
        chk_cnt("aux ref with enable low", 32, 1, aux_rises);
        bus(1, `PCS_OFS_OUT1, 32'h115);
        pin(0);
        meas(256);
        chk_cnt("aux copy with enable low", 0, 0, aux_rises);
        pin(1);
        meas(256);
        chk_cnt("aux copy enabled", 32, 1, aux_rises);
        $display("test enable done");
        bus(1, `PCS_OFS_CTRL, 32'h1);
        pin(0);
        meas(256);
        chk_cnt("main in sleep", 0, 0, main_rises);
        chk_cnt("aux in sleep", 0, 0, aux_rises);
        @(posedge clk) ctl_pin <= 1'b1;
        meas(15);
        chk_cnt("main in settle", 0, 0, main_rises);
        pin(1);
        meas(256);
        chk_cnt("main after wake", 32, 1, main_rises);
        $display("test sleep done");
        bus(1, `PCS_OFS_CTRL, 32'h2);
        bus(1, `PCS_OFS_DIV0, 32'h0100_0101);
        bus(1, `PCS_OFS_OUT0, 32'h111);
        bus(1, `PCS_OFS_DIV1, 32'h0200_0101);
        bus(1, `PCS_OFS_OUT1, 32'h112);
        pin(0);
        meas(256);
        chk_cnt("bank zero", 32, 1, main_rises);
        pin(1);
        meas(256);
        chk_cnt("bank one", 8, 1, main_rises);
        bus(0, `PCS_OFS_STAT, 32'h0);
        chk_word("status bank one locked", 32'h9, q & 32'h0000_000f);
        $display("test bank done");
        bus(1, `PCS_OFS_CTRL, 32'h12);
        bus(1, `PCS_OFS_DIV1, 32'h0000_ffff);
        bus(0, `PCS_OFS_DIV1, 32'h0);
        chk_word("write after burn", 32'h0200_0101, q);
        bus(1, 8'h40, 32'hffff_ffff);
        bus(0, 8'h40, 32'h0);
        chk_word("unmapped read", 32'h0, q);
        $display("test burn done");
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk_word("drives in reset", 32'h5, {28'h0, main_drive, aux_drive});
        rst <= 1'b0;
        bus(0, `PCS_OFS_CTRL, 32'h0);
        chk_word("control after reset", 32'h0, q);
        bus(0, `PCS_OFS_DIV1, 32'h0);
        chk_word("divider after reset", `PCS_DIV_RST, q);
        $display("test mid reset done");
        end_of_test();
    end
endmodule
bind pcs_synth_ctrl pcs_synth_ctrl_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctl_pin(ctl_pin), .main_clock_out(main_clock_out),
    .aux_clock_out(aux_clock_out), .main_drive(main_drive), .aux_drive(aux_drive));
